// *** drv_model.sv ***
// Far side: level shifter word log and stepper drivers with switches.
// Assumes the player outputs; each switch byte is {limit, step count}.
`timescale 1ns/100ps
module drv_model (
	// Clock and reset
	input  logic        clk,
	input  logic        rst,
	// From the block
	input  logic [31:0] wave_out,
	input  logic        wave_strobe,
	input  logic [31:0] motor_out,
	// Switches back
	output logic [31:0] motor_in
);
	logic [31:0] words[$];
	int          times[$];
	int          cyc = 0;
	logic [7:0]  cnt[4];
	logic [31:0] last_m = 32'h0;
	always @(posedge clk) begin
		cyc <= rst ? 0 : cyc + 1;
		if (!rst && wave_strobe) begin
			words.push_back(wave_out);
			times.push_back(cyc);
		end
	end
	always @(posedge clk) begin
		last_m <= motor_out;
		for (int p = 0; p < 4; p++) begin
			if (rst)
				cnt[p] <= 8'h00;
			else if (motor_out[8*p] && !last_m[8*p])
				cnt[p] <= cnt[p] + 8'h01;
		end
	end
	// Limit closes after three steps
	always_comb begin
		for (int p = 0; p < 4; p++)
			motor_in[8*p +: 8] = {cnt[p] > 8'h02, cnt[p][6:0]};
	end
endmodule // drv_model

// *** tb.sv ***
// Self-checking bench for the waveform player and motor ports.
// Assumes wave_player, its monitor and drv_model are compiled first.
`timescale 1ns/100ps
module tb;
	logic        clk = 0;
	logic        rst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] rd;
	logic        er;
	wire  [31:0] prdata, wave_out, motor_out, motor_in;
	wire         pready, pslverr, wave_strobe;
	int          err_total = 0;
	int          n_compared = 0;
	always #50 clk = ~clk;
	wave_player wave_player_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .wave_out, .wave_strobe, .motor_out, .motor_in);
	drv_model drv_model_i (.clk, .rst, .wave_out, .wave_strobe, .motor_out, .motor_in);
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Waits on pready; only the watchdog ends a stall
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task t_regs;
		apb(0, 12'h010, 0);
		chk("rate", 32'h2, rd);
		apb(0, 12'h018, 0);
		chk("slverr", 1, {31'h0, er});
		$display("done regs");
	endtask
	task t_motor;
		for (int p = 0; p < 4; p++)
			apb(1, 12'(32 + 4 * p), 32'h40 + 2 * p);
		for (int s = 0; s < 3; s++) begin
			apb(1, 12'h028, 32'h45);
			apb(1, 12'h028, 32'h44);
		end
		apb(0, 12'h038, 0);
		chk("switch", 32'h83, {24'h0, rd[7:0]});
		chk("latch", 32'h46444240, motor_out);
		$display("done motor");
	endtask
	task t_bypass;
		apb(1, 12'h004, 32'ha5c30ff1);
		@(negedge clk);
		chk("bypass", 32'ha5c30ff1, wave_out);
		$display("done bypass");
	endtask
	task t_play(input int rw, input int re, input int rep);
		int b;
		int n;
		apb(1, 12'h00c, 32'h2);
		for (int i = 0; i < 3; i++)
			apb(1, 12'h000, 32'h01010101 * (i + 1));
		apb(1, 12'h008, rep);
		apb(1, 12'h010, rw);
		apb(1, 12'h004, 32'h5a5a0000 + rep);
		apb(1, 12'h00c, 32'h1);
		b = drv_model_i.words.size();
		chk("head", 32'h5a5a0000 + rep, drv_model_i.words[b - 1]);
		n = 0;
		do begin
			apb(0, 12'h00c, 0);
			n++;
		end while (rd[0] !== 1'b0 && n < 100);
		chk("count", 3 * (rep + 1), drv_model_i.words.size() - b);
		for (int k = 0; k < 3 * (rep + 1); k++) begin
			chk("word", 32'h01010101 * (k % 3 + 1), drv_model_i.words[b + k]);
			if (k % 3 != 0)
				chk("slice", re, drv_model_i.times[b + k] - drv_model_i.times[b + k - 1]);
		end
		chk("hold", 32'h03030303, wave_out);
		chk("start", 0, {31'h0, rd[0]});
		apb(1, 12'h004, 32'h5a5a00ff);
		@(posedge clk);
		@(negedge clk);
		chk("tail", 32'h5a5a00ff, drv_model_i.words[$]);
		$display("done play");
	endtask
	task t_fill;
		apb(1, 12'h00c, 32'h2);
		for (int i = 0; i < 16384; i++)
			apb(1, 12'h000, i);
		apb(0, 12'h014, 0);
		chk("full", 1, {31'h0, rd[3]});
		apb(1, 12'h00c, 32'h2);
		apb(0, 12'h014, 0);
		chk("cleared", 0, {31'h0, rd[3]});
		$display("done fill");
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_motor;
		t_bypass;
		t_play(4, 4, 2);
		t_play(0, 2, 1);
		t_fill;
		results;
	end
	// Fill needs about 50k cycles
	initial begin
		#8000000;
		err_total++;
		results;
	end
endmodule // tb

// *** wave_player.v ***
// Waveform player with 16k-word replay FIFO, bypass port and four motor ports.
// Assumes an APB master on the register side; outputs go to level shifters and motor drivers.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "wave_player_defs.vh"

// ----------------------------------------
// Replay FIFO
// ----------------------------------------
module replay_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 16384,
	parameter AW    = 14
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data,
	// Replay control
	input  wire             rewind,
	input  wire             clear,
	output wire             at_end,
	output wire             full
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      count;
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      rd_num;
	reg             out_full;
	wire            pop;
	wire            fetch;
	localparam [31:0] DEPTH_W = DEPTH;

	// Contents are kept after reading so the pass can be replayed
	assign full      = (count == DEPTH_W[AW:0]);
	assign in_ready  = !full && !clear;
	assign out_valid = out_full;
	assign pop       = out_full && out_ready;
	assign at_end    = (rd_num == count);
	assign fetch     = !at_end && (!out_full || pop) && !rewind;

	always @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (rst || clear) begin
			count    <= {(AW+1){1'b0}};
			wr_ptr   <= {AW{1'b0}};
			rd_ptr   <= {AW{1'b0}};
			rd_num   <= {(AW+1){1'b0}};
			out_full <= 1'b0;
			out_data <= {WIDTH{1'b0}};
		end else begin
			if (in_valid && in_ready) begin
				wr_ptr <= wr_ptr + 1'b1;
				count  <= count + 1'b1;
			end
			if (rewind) begin
				rd_ptr   <= {AW{1'b0}};
				rd_num   <= {(AW+1){1'b0}};
				out_full <= 1'b0;
			end else if (fetch) begin
				out_data <= mem[rd_ptr];
				rd_ptr   <= rd_ptr + 1'b1;
				rd_num   <= rd_num + 1'b1;
				out_full <= 1'b1;
			end else if (pop) begin
				out_full <= 1'b0;
			end
		end
	end
endmodule // replay_fifo

// ----------------------------------------
// Top level
// ----------------------------------------
module wave_player (
	// Clock and reset
	input  wire                    clk,
	input  wire                    rst,
	// APB slave
	input  wire                    psel,
	input  wire                    penable,
	input  wire                    pwrite,
	input  wire [11:0]             paddr,
	input  wire [31:0]             pwdata,
	output reg  [31:0]             prdata,
	output wire                    pready,
	output wire                    pslverr,
	// Waveform output
	output reg  [`WAVE_WIDTH-1:0]  wave_out,
	output reg                     wave_strobe,
	// Motor ports
	output wire [31:0]             motor_out,
	input  wire [31:0]             motor_in
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_PLAY  = 2'd1;
	localparam ST_WAIT  = 2'd2;

	reg  [1:0]                state;
	reg  [1:0]                next_state;
	reg                       start;
	reg  [`REPEAT_WIDTH-1:0]  repeat_cnt;
	reg  [`REPEAT_WIDTH-1:0]  pass_cnt;
	reg  [`RATE_WIDTH-1:0]    rate;
	reg  [`RATE_WIDTH-1:0]    slice_cnt;
	reg  [`MOTOR_WIDTH-1:0]   motor_latch [0:`MOTOR_PORTS-1];
	reg                       rd_err;
	wire                      wr_en;
	wire                      rd_en;
	localparam [31:0]         SLICE_MIN_W = `SLICE_MIN_CYC;
	wire                      fifo_out_valid;
	wire [`WAVE_WIDTH-1:0]    fifo_out_data;
	wire                      fifo_at_end;
	wire                      fifo_full;
	wire                      slice_done;
	wire                      take;
	wire                      rewind;
	wire                      clear;
	wire                      bypass_wr;
	wire                      motor_wr;
	wire [1:0]                motor_sel;
	wire [`RATE_WIDTH-1:0]    rate_eff;

	// Data writes wait while the FIFO is full; that stall is the back-pressure
	assign wr_en     = psel && penable && pwrite && pready;
	assign rd_en     = psel && penable && !pwrite;
	// Full flag decoded from the count register, so pready never loops through the clear path
	assign pready    = !(pwrite && paddr == `OFS_FIFO_DATA && fifo_full);
	assign pslverr   = psel && penable && !pwrite && rd_err;
	assign bypass_wr = wr_en && paddr == `OFS_BYPASS;
	assign clear     = wr_en && paddr == `OFS_CONTROL && pwdata[`CTRL_CLEAR_BIT] && !start;
	assign motor_sel = paddr[3:2];
	assign motor_wr  = wr_en && paddr[11:4] == `OFS_MOTOR_OUT0 >> 4;

	replay_fifo #(
		.WIDTH (`WAVE_WIDTH),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (wr_en && paddr == `OFS_FIFO_DATA),
		.in_ready  (),
		.in_data   (pwdata),
		.out_valid (fifo_out_valid),
		.out_ready (take),
		.out_data  (fifo_out_data),
		.rewind    (rewind),
		.clear     (clear),
		.at_end    (fifo_at_end),
		.full      (fifo_full)
	);

	// ----------------------------------------
	// Slice pacing
	// ----------------------------------------
	// floor at 200 ns slice
	assign rate_eff   = (rate < SLICE_MIN_W[`RATE_WIDTH-1:0]) ?
	                    SLICE_MIN_W[`RATE_WIDTH-1:0] : rate;
	assign slice_done = (slice_cnt == {`RATE_WIDTH{1'b0}});
	assign take       = (state == ST_PLAY) && slice_done && fifo_out_valid;
	assign rewind     = (state == ST_PLAY) && fifo_at_end && !fifo_out_valid
	                    && slice_done && (pass_cnt != {`REPEAT_WIDTH{1'b0}});

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start) begin
					next_state = ST_PLAY;
				end
			end
			ST_PLAY: begin
				if (fifo_at_end && !fifo_out_valid && slice_done
				    && pass_cnt == {`REPEAT_WIDTH{1'b0}}) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			state       <= ST_IDLE;
			slice_cnt   <= {`RATE_WIDTH{1'b0}};
			pass_cnt    <= {`REPEAT_WIDTH{1'b0}};
			wave_out    <= `WAVE_RESET;
			wave_strobe <= 1'b0;
		end else begin
			state       <= next_state;
			wave_strobe <= 1'b0;
			if (state == ST_IDLE && start) begin
				pass_cnt  <= repeat_cnt;
				slice_cnt <= {`RATE_WIDTH{1'b0}};
			end else if (take) begin
				slice_cnt <= rate_eff - 1'b1;
			end else if (!slice_done) begin
				slice_cnt <= slice_cnt - 1'b1;
			end
			if (rewind) begin
				pass_cnt <= pass_cnt - 1'b1;
			end
			if (take) begin
				wave_out    <= fifo_out_data;
				wave_strobe <= 1'b1;
			end else if (bypass_wr) begin
				wave_out    <= pwdata;
				wave_strobe <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			start      <= 1'b0;
			repeat_cnt <= `REPEAT_RESET;
			rate       <= `RATE_RESET;
		end else begin
			if (state == ST_WAIT) begin
				start <= 1'b0;
			end else if (wr_en && paddr == `OFS_CONTROL) begin
				start <= pwdata[`CTRL_START_BIT];
			end
			if (wr_en && paddr == `OFS_REPEAT && state == ST_IDLE) begin
				repeat_cnt <= pwdata;
			end
			if (wr_en && paddr == `OFS_RATE) begin
				rate <= pwdata[`RATE_WIDTH-1:0];
			end
		end
	end

	integer j;
	always @(posedge clk) begin
		if (rst) begin
			for (j = 0; j < `MOTOR_PORTS; j = j + 1) begin
				motor_latch[j] <= `MOTOR_RESET;
			end
		end else if (motor_wr) begin
			motor_latch[motor_sel] <= pwdata[`MOTOR_WIDTH-1:0];
		end
	end

	genvar i;
	generate
		for (i = 0; i < `MOTOR_PORTS; i = i + 1) begin : g_motor
			assign motor_out[i*`MOTOR_WIDTH +: `MOTOR_WIDTH] = motor_latch[i];
		end
	endgenerate

	always @* begin
		prdata = 32'h00000000;
		rd_err = 1'b0;
		if (rd_en) begin
			case (paddr)
				`OFS_REPEAT:  prdata = repeat_cnt;
				`OFS_CONTROL: prdata = {31'h00000000, start};
				`OFS_RATE:    prdata = {16'h0000, rate};
				`OFS_STATUS:  prdata = {28'h0000000, fifo_full, fifo_at_end, state};
				`OFS_MOTOR_OUT0, `OFS_MOTOR_OUT0 + 12'h004,
				`OFS_MOTOR_OUT0 + 12'h008, `OFS_MOTOR_OUT0 + 12'h00c:
					prdata = {24'h000000, motor_latch[motor_sel]};
				`OFS_MOTOR_IN0, `OFS_MOTOR_IN0 + 12'h004,
				`OFS_MOTOR_IN0 + 12'h008, `OFS_MOTOR_IN0 + 12'h00c:
					prdata = {24'h000000, motor_in[motor_sel*`MOTOR_WIDTH +: `MOTOR_WIDTH]};
				`OFS_FIFO_DATA, `OFS_BYPASS: prdata = 32'h00000000;
				default: rd_err = 1'b1;
			endcase
		end
	end
endmodule // wave_player

// *** wave_player_defs.vh ***
// Constants for the waveform player and motor port block.
// Assumes a 10 MHz clock and an APB register bus with 32-bit data.
`ifndef WAVE_PLAYER_DEFS_VH
`define WAVE_PLAYER_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_FIFO_DATA   12'h000
`define OFS_BYPASS      12'h004
`define OFS_REPEAT      12'h008
`define OFS_CONTROL     12'h00c
`define OFS_RATE        12'h010
`define OFS_STATUS      12'h014
`define OFS_MOTOR_OUT0  12'h020
`define OFS_MOTOR_IN0   12'h030

// ----------------------------------------
// Fields and widths
// ----------------------------------------
`define CTRL_START_BIT  0
`define CTRL_CLEAR_BIT  1
`define WAVE_WIDTH      32
`define FIFO_DEPTH      16384
`define FIFO_AW         14
`define MOTOR_PORTS     4
`define MOTOR_WIDTH     8
`define RATE_WIDTH      16
`define REPEAT_WIDTH    32

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS   100
`define SLICE_MIN_NS    200
`define SLICE_MIN_CYC   ((`SLICE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RATE_RESET      16'h0002
`define REPEAT_RESET    32'h00000000
`define WAVE_RESET      32'h00000000
`define MOTOR_RESET     8'h00

`endif

// *** wave_player_monitor.sv ***
// Port checker for the waveform player and motor ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
// --
// Checker
// --
module wave_player_monitor (
	// Clock and reset
	input logic        clk,
	input logic        rst,
	// Register bus
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	// Waveform and motors
	input logic [31:0] wave_out,
	input logic        wave_strobe,
	input logic [31:0] motor_out,
	input logic [31:0] motor_in
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);
	wire        acc = psel && penable;
	wire        mwr = acc && pwrite && paddr[11:4] == 8'h02;
	logic [1:0] mp;
	// Port of the previous access
	always @(posedge clk) begin
		mp <= paddr[3:2];
	end
	strobe_pulse_a: assert property (wave_strobe |=> !wave_strobe)
		else $error("strobe held two cycles");
	wave_hold_a: assert property (!wave_strobe |-> $stable(wave_out))
		else $error("output moved without strobe");
	bypass_load_a: assert property (acc && pwrite && paddr == 12'h004 |=> wave_strobe)
		else $error("bypass word not loaded");
	motor_write_a: assert property (mwr |=> motor_out[8*mp +: 8] == $past(pwdata[7:0]))
		else $error("motor latch not written");
	motor_hold_a: assert property (!mwr |=> $stable(motor_out))
		else $error("motor latch moved");
	switch_read_a: assert property (acc && !pwrite && paddr[11:4] == 8'h03
		&& $past(motor_in) == motor_in && $past(motor_in, 2) == motor_in
		|-> prdata[7:0] == motor_in[8*paddr[3:2] +: 8])
		else $error("switch read wrong");
	bad_addr_a: assert property (acc && !pwrite && paddr == 12'h018 |-> pslverr)
		else $error("no error on unmapped read");
	no_stall_a: assert property (psel && paddr != 12'h000 |-> pready)
		else $error("stall off the fifo port");
	cover property (acc && pwrite && paddr == 12'h004);
	cover property (wave_strobe ##2 wave_strobe);
	cover property (acc && !pwrite && paddr[11:4] == 8'h03);
endmodule // wave_player_monitor
bind wave_player wave_player_monitor wave_player_monitor_i (.clk, .rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wave_out, .wave_strobe,
	.motor_out, .motor_in);
